// ### design/nvc_pkg.sv
// Purpose: shared constants and carriers for the nested vector controller
// Assumes: 50 MHz core clock, one clock domain
// Notes: vector numbers follow word offsets in the vector table
package nvc_pkg;
    localparam int NVC_NUM_IRQ = 32;
    localparam int NVC_NUM_EXT = 16;
    localparam int NVC_PRIO_W = 2;
    localparam int NVC_VEC_W = 6;
    localparam int NVC_ADDR_W = 32;
    localparam int NVC_ENTRY_BYTES = 4;
    // table offsets of system entries and of peripheral entry 0
    localparam logic [7:0] NVC_OFS_RESET = 8'h04;
    localparam logic [7:0] NVC_OFS_NMI = 8'h08;
    localparam logic [7:0] NVC_OFS_FAULT = 8'h0C;
    localparam logic [7:0] NVC_OFS_SVCALL = 8'h2C;
    localparam logic [7:0] NVC_OFS_PENDSR = 8'h38;
    localparam logic [7:0] NVC_OFS_TICK = 8'h3C;
    localparam logic [7:0] NVC_OFS_IRQ0 = 8'h40;
    localparam int NVC_STACK_CYC = 16;
    localparam int NVC_UNSTACK_CYC = 16;
    localparam int NVC_TICK_W = 24;
    localparam logic [23:0] NVC_TICK_RELOAD_RST = 24'h00_FFFF;
    localparam logic [1:0] NVC_PRIO_RST = 2'h0;

    typedef enum logic [2:0] {
        NVC_IDLE = 3'b000,
        NVC_FETCH = 3'b001,
        NVC_STACK = 3'b010,
        NVC_RUN = 3'b011,
        NVC_UNSTACK = 3'b100
    } nvc_state_t;

    // request seen by the core
    typedef struct packed {
        logic fetch;
        logic [31:0] addr;
        logic handler_go;
        logic [5:0] vector;
    } nvc_core_req_t;
endpackage

// ### design/nvc_arbiter.sv
// Purpose: picks most urgent pending request among peripheral vectors
// Assumes: purely combinational, same clock domain as caller
// Notes: lower level value wins, lower index breaks ties
`timescale 1ns/1ps
`default_nettype none
module nvc_arbiter #(
    parameter int N = 32
) (
    input wire logic [N-1:0] pend,
    input wire logic [2*N-1:0] prio,
    output logic found,
    output logic [4:0] index,
    output logic [1:0] level
);
    // scan from highest index down so lower index overwrites on tie
    always_comb begin
        found = 1'b0;
        index = 5'h0;
        level = 2'h3;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend[i] && (!found || prio[2*i +: 2] <= level)) begin
                found = 1'b1;
                index = 5'(i);
                level = prio[2*i +: 2];
            end
        end
    end
endmodule
`default_nettype wire

// ### design/nvc_top.sv
// Purpose: nested vector controller core-side sequencer
// Assumes: sources synchronous except ext lines; core fetches by addr
// Notes: priority and enable inputs are static configuration levels
`timescale 1ns/1ps
`default_nettype none
module nvc_top
    import nvc_pkg::*;
#(
    parameter int NUM_IRQ = nvc_pkg::NVC_NUM_IRQ,
    parameter logic [31:0] TABLE_BASE = 32'h0000_0000
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [NUM_IRQ-1:0] periph_irq,
    input wire logic [15:0] ext_line_interrupt,
    input wire logic [NUM_IRQ-1:0] irq_enable,
    input wire logic [2*NUM_IRQ-1:0] irq_prio,
    input wire logic [5:0] sys_prio,
    input wire logic global_mask,
    input wire logic parity_error,
    input wire logic clock_security,
    input wire logic bus_fault,
    input wire logic super_call_exec,
    input wire logic pend_service_set,
    input wire logic tick_enable,
    input wire logic [23:0] tick_reload,
    input wire logic handler_return,
    output logic fetch_valid,
    output logic [31:0] fetch_addr,
    output logic handler_start,
    output logic [5:0] active_vector,
    output logic busy
);
    import nvc_pkg::*;

    nvc_state_t state_q;
    logic [4:0] cnt_q;
    logic [15:0] ext_s1_q, ext_s2_q, ext_s3_q;
    logic [NUM_IRQ-1:0] pend_q;
    logic nmi_q, fault_q, scall_q, psv_q, tick_q;
    logic [23:0] tick_cnt_q;
    logic [5:0] vec_q;
    logic [NUM_IRQ-1:0] req;
    logic arb_found;
    logic [4:0] arb_idx;
    logic [1:0] arb_lvl;
    logic take;
    logic [5:0] take_vec;
    logic [1:0] best_lvl;
    logic [NUM_IRQ-1:0] clr_irq;
    logic clr_nmi, clr_fault, clr_scall, clr_psv, clr_tick;

    // external lines: two sync flops then edge detect on stage two
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_s1_q <= 16'h0000;
            ext_s2_q <= 16'h0000;
            ext_s3_q <= 16'h0000;
        end else begin
            ext_s1_q <= ext_line_interrupt;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    // one line per peripheral, ext lines OR into first 16 channels
    always_comb begin
        req = periph_irq;
        req[15:0] = periph_irq[15:0] | (ext_s2_q & ~ext_s3_q);
    end

    // core tick 24-bit down counter
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_q <= NVC_TICK_RELOAD_RST;
        end else if (!tick_enable) begin
            tick_cnt_q <= tick_reload;
        end else if (tick_cnt_q == 24'h00_0000) begin
            tick_cnt_q <= tick_reload;
        end else begin
            tick_cnt_q <= tick_cnt_q - 24'h00_0001;
        end
    end
    wire tick_hit = tick_enable && tick_cnt_q == 24'h00_0000;

    // sticky pending flags, set wins over clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_q <= '0;
            nmi_q <= 1'b0;
            fault_q <= 1'b0;
            scall_q <= 1'b0;
            psv_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            pend_q <= (pend_q & ~clr_irq) | req;
            nmi_q <= (nmi_q & ~clr_nmi) | parity_error |
                clock_security;
            fault_q <= (fault_q & ~clr_fault) | bus_fault;
            scall_q <= (scall_q & ~clr_scall) | super_call_exec;
            psv_q <= (psv_q & ~clr_psv) | pend_service_set;
            tick_q <= (tick_q & ~clr_tick) | tick_hit;
        end
    end

    nvc_arbiter #(.N(NUM_IRQ)) u_arb (
        .pend(pend_q & irq_enable),
        .prio(irq_prio),
        .found(arb_found),
        .index(arb_idx),
        .level(arb_lvl)
    );

    // select: nmi, fault fixed above all; then programmable by level
    always_comb begin
        take = 1'b0;
        take_vec = 6'h0;
        best_lvl = 2'h3;
        if (nmi_q) begin
            take = 1'b1;
            take_vec = 6'(NVC_OFS_NMI >> 2);
        end else if (fault_q) begin
            take = 1'b1;
            take_vec = 6'(NVC_OFS_FAULT >> 2);
        end else if (!global_mask) begin
            // lower vector first, so strict compare keeps earlier on tie
            if (scall_q) begin
                take = 1'b1;
                take_vec = 6'(NVC_OFS_SVCALL >> 2);
                best_lvl = sys_prio[1:0];
            end
            if (psv_q && (!take || sys_prio[3:2] < best_lvl)) begin
                take = 1'b1;
                take_vec = 6'(NVC_OFS_PENDSR >> 2);
                best_lvl = sys_prio[3:2];
            end
            if (tick_q && (!take || sys_prio[5:4] < best_lvl)) begin
                take = 1'b1;
                take_vec = 6'(NVC_OFS_TICK >> 2);
                best_lvl = sys_prio[5:4];
            end
            if (arb_found && (!take || arb_lvl < best_lvl)) begin
                take = 1'b1;
                take_vec = 6'(NVC_OFS_IRQ0 >> 2) + 6'(arb_idx);
                best_lvl = arb_lvl;
            end
        end
    end

    // clear the flag of the vector being accepted
    wire accept = take && (state_q == NVC_IDLE ||
        (state_q == NVC_RUN && handler_return));
    always_comb begin
        clr_irq = '0;
        clr_nmi = accept && take_vec == 6'(NVC_OFS_NMI >> 2);
        clr_fault = accept && take_vec == 6'(NVC_OFS_FAULT >> 2);
        clr_scall = accept && take_vec == 6'(NVC_OFS_SVCALL >> 2);
        clr_psv = accept && take_vec == 6'(NVC_OFS_PENDSR >> 2);
        clr_tick = accept && take_vec == 6'(NVC_OFS_TICK >> 2);
        if (accept && take_vec >= 6'(NVC_OFS_IRQ0 >> 2)) begin
            clr_irq[arb_idx] = 1'b1;
        end
    end

    // sequencer: fetch, stack, run, unstack or chain
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= NVC_IDLE;
            cnt_q <= 5'h00;
            vec_q <= 6'(NVC_OFS_RESET >> 2);
        end else begin
            unique case (state_q)
                NVC_IDLE: begin
                    if (take) begin
                        vec_q <= take_vec;
                        state_q <= NVC_FETCH;
                    end
                end
                NVC_FETCH: begin
                    cnt_q <= 5'h01;
                    state_q <= NVC_STACK;
                end
                NVC_STACK: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == 5'(NVC_STACK_CYC)) begin
                        state_q <= NVC_RUN;
                    end
                end
                NVC_RUN: begin
                    if (handler_return && take) begin
                        vec_q <= take_vec; // tail chain
                        state_q <= NVC_FETCH;
                    end else if (handler_return) begin
                        cnt_q <= 5'h01;
                        state_q <= NVC_UNSTACK;
                    end
                end
                NVC_UNSTACK: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == 5'(NVC_UNSTACK_CYC)) begin
                        state_q <= NVC_IDLE;
                    end
                end
                default: state_q <= NVC_IDLE;
            endcase
        end
    end

    // registered core outputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fetch_valid <= 1'b0;
            fetch_addr <= 32'h0000_0000;
            handler_start <= 1'b0;
            active_vector <= 6'h00;
            busy <= 1'b0;
        end else begin
            fetch_valid <= state_q == NVC_FETCH;
            fetch_addr <= TABLE_BASE +
                32'(vec_q) * 32'(NVC_ENTRY_BYTES);
            handler_start <= state_q == NVC_STACK &&
                cnt_q == 5'(NVC_STACK_CYC);
            active_vector <= vec_q;
            busy <= state_q != NVC_IDLE;
        end
    end

    // entry: exactly 16 stacking cycles after fetch
    stack_time_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        fetch_valid |-> ##16 handler_start)
        else $error("handler start not 16 cycles after fetch");
    // masked peripheral never accepted
    mask_block_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_q == NVC_IDLE && global_mask && !nmi_q && !fault_q)
        |=> state_q == NVC_IDLE)
        else $error("masked request was accepted");
    // nmi beats everything
    nmi_first_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_q == NVC_IDLE && nmi_q) |=> vec_q == 6'h02)
        else $error("nmi not taken first");
    // bus memory fault beats everything but nmi, mask or not
    fault_first_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_q == NVC_IDLE && fault_q && !nmi_q) |=> vec_q == 6'h03)
        else $error("bus memory fault not taken");
    // fetched word is the table entry of the vector shown
    entry_word_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        fetch_valid |->
        fetch_addr == TABLE_BASE + {24'h00_0000, active_vector, 2'b00})
        else $error("fetch address is not the vector entry word");
    // unstack lasts exactly 16 cycles, then back to idle
    unstack_time_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(state_q == NVC_UNSTACK) |-> (state_q == NVC_UNSTACK) [*8]
        ##1 (state_q == NVC_UNSTACK) [*8] ##1 (state_q == NVC_IDLE))
        else $error("unstack length wrong");
endmodule
`default_nettype wire

// ### verif/nvc_core_model.sv
// Purpose: behavioural core that runs each handler and returns
// Assumes: handler_start is a one-cycle pulse from the controller
// Notes: handler body length is a fixed count of cycles
`timescale 1ns/1ps
`default_nettype none
module nvc_core_model #(
    parameter int RUN_LEN = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic handler_start,
    output logic handler_return
);
    int run_q;
    // run the handler, then pulse return once while running
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            run_q <= 0;
            handler_return <= 1'b0;
        end else begin
            handler_return <= (run_q == 1);
            if (handler_start) begin
                run_q <= RUN_LEN;
            end else if (run_q > 0) begin
                run_q <= run_q - 1;
            end
        end
    end
endmodule
`default_nettype wire

// ### verif/tb_nested_vectored_irq_controller.sv
// Purpose: self-checking bench for the nested vector controller
// Assumes: core model answers every handler with a return pulse
// Notes: expected vectors come from a reference arbiter in the bench
`timescale 1ns/1ps
`default_nettype none
module tb_nested_vectored_irq_controller;
    import nvc_pkg::*;
    logic clk, reset_n, global_mask, parity_error, clock_security;
    logic bus_fault, super_call_exec, pend_service_set, tick_enable;
    logic handler_return;
    logic fetch_valid, handler_start, busy;
    logic [31:0] periph_irq, irq_enable, fetch_addr;
    logic [15:0] ext_line_interrupt;
    logic [63:0] irq_prio;
    logic [5:0] sys_prio, active_vector;
    logic [23:0] tick_reload;
    int err_total = 0;
    int checks_done = 0;
    int a, b, n;
    int exp_q[$];
    int sys_vec[5] = '{2, 2, 3, 11, 14}; // table offset divided by 4

    nvc_top uut (.clk, .reset_n, .periph_irq, .ext_line_interrupt,
        .irq_enable, .irq_prio, .sys_prio, .global_mask, .parity_error,
        .clock_security, .bus_fault, .super_call_exec, .pend_service_set,
        .tick_enable,
        .tick_reload, .handler_return, .fetch_valid, .fetch_addr,
        .handler_start, .active_vector, .busy);
    nvc_core_model #(.RUN_LEN(4)) core (.clk, .reset_n, .handler_start,
        .handler_return);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic step();
        @(posedge clk);
        #2;
    endtask

    // reference arbiter: lower level wins, lower index breaks ties
    function automatic int pick(input int x, input int y);
        int px, py;
        px = irq_prio[2*x +: 2];
        py = irq_prio[2*y +: 2];
        if (px < py || (px == py && x < y)) begin
            return x;
        end
        return y;
    endfunction

    // wait for entry, check table word address and stacking time
    task automatic take(input int vec);
        int k;
        k = 0;
        while (fetch_valid !== 1'b1 && k < 300) begin
            step();
            k++;
        end
        check(32'(fetch_valid), 32'h0000_0001);
        check(fetch_addr, 32'(NVC_ENTRY_BYTES * vec));
        k = 0;
        do begin
            step();
            k++;
        end while (handler_start !== 1'b1 && k < 40);
        check(32'(k), 32'(NVC_STACK_CYC));
        check(32'(active_vector), 32'(vec));
        check(32'(busy), 32'h0000_0001);
    endtask

    // cycles from the return pulse to the next fetch
    task automatic ret_gap(output int g);
        g = 0;
        while (handler_return !== 1'b1 && g < 100) begin
            step();
            g++;
        end
        g = 0;
        while (fetch_valid !== 1'b1 && g < 100) begin
            step();
            g++;
        end
    endtask

    task automatic pulse_sys(input int s, input logic v);
        case (s)
            0: parity_error = v;
            1: clock_security = v;
            2: bus_fault = v;
            3: super_call_exec = v;
            default: pend_service_set = v;
        endcase
    endtask

    // watchdog: far beyond the thousand or so cycles the tests need
    initial begin
        #(20 * 20000);
        err_total++;
        final_report();
    end

    initial begin
        {periph_irq, ext_line_interrupt, irq_prio, sys_prio} = '0;
        {global_mask, parity_error, clock_security, bus_fault} = '0;
        {super_call_exec, pend_service_set, tick_enable} = '0;
        irq_enable = 32'hffff_ffff;
        tick_reload = 24'h00_0040;
        reset_n = 1'b0;
        void'($urandom(32'hdfea2201));
        repeat (8) @(posedge clk);
        #2 reset_n = 1'b1;
        step();
        check(fetch_addr, 32'(NVC_OFS_RESET));
        check(32'(active_vector), 32'(NVC_OFS_RESET >> 2));
        // system exceptions; mask is up for the first three sources
        for (int s = 0; s < 5; s++) begin
            global_mask = (s < 3);
            pulse_sys(s, 1'b1);
            step();
            pulse_sys(s, 1'b0);
            take(sys_vec[s]);
            repeat (25) step();
            check(32'(busy), 32'h0000_0000);
        end
        // service call and pend service requests at once, random levels
        sys_prio = 6'($urandom);
        super_call_exec = 1'b1;
        pend_service_set = 1'b1;
        step();
        {super_call_exec, pend_service_set} = '0;
        n = (sys_prio[3:2] < sys_prio[1:0]) ? sys_vec[4] : sys_vec[3];
        take(n);
        ret_gap(a);
        check(32'(a < NVC_UNSTACK_CYC), 32'h0000_0001);
        take(sys_vec[3] + sys_vec[4] - n);
        repeat (25) step();
        sys_prio = '0;
        $display("test system exceptions done");
        // masked peripheral stays pending until the mask drops
        global_mask = 1'b1;
        periph_irq[31] = 1'b1;
        step();
        periph_irq = '0;
        for (int i = 0; i < 30; i++) begin
            step();
            check(32'(fetch_valid), 32'h0000_0000);
        end
        global_mask = 1'b0;
        take(47);
        repeat (25) step();
        $display("test mask done");
        // two requests at once, second one chains on return
        for (int i = 0; i < 8; i++) begin
            irq_prio = {$urandom, $urandom};
            a = $urandom_range(31);
            b = (a + 1 + $urandom_range(30)) % 32;
            periph_irq[a] = 1'b1;
            periph_irq[b] = 1'b1;
            step();
            periph_irq = '0;
            exp_q.push_back(pick(a, b));
            exp_q.push_back(a + b - pick(a, b));
            take(16 + exp_q.pop_front());
            ret_gap(n);
            check(32'(n < NVC_UNSTACK_CYC), 32'h0000_0001);
            take(16 + exp_q.pop_front());
            repeat (25) step();
        end
        $display("test priority and chaining done");
        // a request during unstacking waits the full restore time
        periph_irq[0] = 1'b1;
        step();
        periph_irq = '0;
        take(16);
        while (handler_return !== 1'b1) step();
        periph_irq[1] = 1'b1;
        step();
        periph_irq = '0;
        n = 1;
        while (fetch_valid !== 1'b1 && n < 100) begin
            step();
            n++;
        end
        a = (n >= NVC_UNSTACK_CYC && n < NVC_UNSTACK_CYC + 8);
        check(32'(a), 32'h0000_0001);
        take(17);
        repeat (25) step();
        $display("test unstacking done");
        // core tick counter and external lines
        tick_enable = 1'b1;
        take(15);
        tick_enable = 1'b0;
        repeat (25) step();
        for (int i = 0; i < 16; i += 15) begin
            ext_line_interrupt[i] = 1'b1;
            take(16 + i);
            ext_line_interrupt = '0;
            repeat (25) step();
        end
        $display("test tick and external lines done");
        // reset in mid-handler: outputs clear, nothing left pending
        periph_irq[2] = 1'b1;
        step();
        periph_irq = '0;
        take(18);
        reset_n = 1'b0;
        step();
        check(32'(busy), 32'h0000_0000);
        check(32'(active_vector), 32'h0000_0000);
        reset_n = 1'b1;
        step();
        check(fetch_addr, 32'(NVC_OFS_RESET));
        for (int i = 0; i < 30; i++) begin
            step();
            check(32'(busy), 32'h0000_0000);
        end
        $display("test mid-run reset done");
        final_report();
    end
endmodule
`default_nettype wire
